// *** core/fault_irq_params.svh ***
`ifndef FAULT_IRQ_PARAMS_SVH
`define FAULT_IRQ_PARAMS_SVH
`define ADDR_ENABLE 7'h01
`define ADDR_USER_LO 7'h02
`define ADDR_USER_HI 7'h09
`define ADDR_FLAGS 7'h0C
`define ADDR_MASKS 7'h0D
`define ADDR_DETAIL_FIRST 7'h27
`define ADDR_DETAIL_LAST 7'h2A
`define ADDR_KEY 7'h2E
`define ADDR_NVM_CTRL 7'h2F
`define ADDR_CUST_FIRST 7'h30
`define ADDR_CUST_LAST 7'h35
`define RST_ENABLE 8'h82
`define RST_MASKS 8'h00
`define RST_NVM_CTRL 8'h00
`define BIT_FAST_SD_EN 7
`define BIT_RAILS_EN 0
`define BIT_GUARD 0
`define BIT_COMMIT 1
`define BIT_FLG_RAIL 7
`define BIT_FLG_LAMP 6
`define BIT_FLG_PIN 5
`define BIT_FLG_BAT_CUT 4
`define BIT_FLG_BAT_WARN 3
`define BIT_FLG_TS_CUT 2
`define BIT_FLG_THERMAL_CAUTION_FLAG 1
`define KEY_FIRST 8'hBA
`define KEY_SECOND 8'hBE
`define KEY_READ_LOCKED 8'h00
`define KEY_READ_UNLOCKED 8'h01
`define CMD_WRITE_BIT 7
`endif

// *** core/fault_irq_pkg.sv ***
package fault_irq_pkg;
	typedef enum logic [1:0]
	{
		KEY_LOCKED = 2'b00,
		KEY_HALF = 2'b01,
		KEY_OPEN = 2'b10
	} key_state_e;

	typedef struct packed
	{
		logic valid;
		logic [7:0] cmd;
		logic [7:0] wdata;
	} reg_acc_s;

	typedef struct packed
	{
		logic power_pin_event;
		logic battery_cutoff;
		logic battery_caution;
		logic thermal_cutoff;
		logic thermal_caution;
		logic mirror_power_good_error;
		logic mirror_buck1_pg_error;
		logic mirror_buck1_ov_error;
		logic mirror_buck2_pg_error;
		logic mirror_buck2_ov_error;
		logic ldo1_pg_error;
		logic ldo1_ov_error;
		logic ldo2_pg_error;
		logic ldo2_ov_error;
		logic aux_buck_pg_error;
		logic aux_buck_ov_error;
		logic lamp_ctrl1_pg_error;
		logic lamp_ctrl1_ov_error;
		logic lamp_ctrl2_pg_error;
		logic lamp_ctrl2_ov_error;
	} fault_in_s;
endpackage

// *** core/fault_irq_protect.sv ***
`timescale 1ns/1ps
`include "fault_irq_params.svh"
module fault_irq_protect
	import fault_irq_pkg::*;
#(
	parameter int N_DETAIL = 4,
	parameter int N_CUST = 6
)
(
	input logic i_clk_sys,
	input logic i_resetn,
	input logic i_projector_power_pin,
	input fault_in_s i_faults,
	input reg_acc_s i_acc,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic o_int_n,
	output logic o_fast_shutdown,
	output logic o_normal_shutdown,
	output logic o_mirror_rails_enable,
	output logic o_nvm_commit
);
	logic [7:0] enable_r;
	logic [7:0] flags_r;
	logic [7:0] masks_r;
	logic [7:0] nvm_ctrl_r;
	logic [7:0] detail_r [N_DETAIL];
	logic [7:0] detail_raw [N_DETAIL];
	logic [7:0] cust_r [N_CUST];
	logic [7:0] flag_set;
	logic [7:0] rdata_nxt;
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic int_n_r;
	logic fast_sd_r;
	logic normal_sd_r;
	key_state_e key_r;
	key_state_e key_nxt;
	logic wr;
	logic rd;
	logic [6:0] addr;
	logic mirror_rail_error;
	logic rail_error;
	logic lamp_error;
	logic fast_qualify;
	logic any_fault;
	logic unlocked;

	function automatic logic in_range(input logic [6:0] a, input logic [6:0] lo, input logic [6:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic user_wr_ok(input logic [6:0] a, input logic guard);
		user_wr_ok = !guard || in_range(a, `ADDR_USER_LO, `ADDR_USER_HI);
	endfunction

	// command decode
	assign wr = i_acc.valid && i_acc.cmd[`CMD_WRITE_BIT];
	assign rd = i_acc.valid && !i_acc.cmd[`CMD_WRITE_BIT];
	assign addr = i_acc.cmd[6:0];
	assign unlocked = (key_r == KEY_OPEN);

	// fault aggregation
	assign mirror_rail_error = i_faults.mirror_power_good_error | i_faults.mirror_buck1_pg_error
		| i_faults.mirror_buck1_ov_error | i_faults.mirror_buck2_pg_error | i_faults.mirror_buck2_ov_error
		| i_faults.ldo1_pg_error | i_faults.ldo1_ov_error | i_faults.ldo2_pg_error
		| i_faults.ldo2_ov_error;
	assign rail_error = mirror_rail_error | i_faults.aux_buck_pg_error | i_faults.aux_buck_ov_error;
	assign lamp_error = i_faults.lamp_ctrl1_pg_error | i_faults.lamp_ctrl1_ov_error
		| i_faults.lamp_ctrl2_pg_error | i_faults.lamp_ctrl2_ov_error;
	assign fast_qualify = i_faults.battery_cutoff | i_faults.thermal_cutoff | mirror_rail_error
		| i_faults.lamp_ctrl1_ov_error | i_faults.lamp_ctrl2_ov_error;
	assign any_fault = rail_error | lamp_error | i_faults.battery_cutoff | i_faults.thermal_cutoff;

	always_comb
	begin
		flag_set = 8'h00;
		flag_set[`BIT_FLG_RAIL] = rail_error;
		flag_set[`BIT_FLG_LAMP] = lamp_error;
		flag_set[`BIT_FLG_PIN] = i_faults.power_pin_event;
		flag_set[`BIT_FLG_BAT_CUT] = i_faults.battery_cutoff;
		flag_set[`BIT_FLG_BAT_WARN] = i_faults.battery_caution;
		flag_set[`BIT_FLG_TS_CUT] = i_faults.thermal_cutoff;
		flag_set[`BIT_FLG_THERMAL_CAUTION_FLAG] = i_faults.thermal_caution;
	end

	always_comb
	begin
		detail_raw[0] = {i_faults.ldo2_pg_error, i_faults.ldo1_ov_error, i_faults.ldo1_pg_error,
			i_faults.mirror_buck2_ov_error, i_faults.mirror_buck2_pg_error, i_faults.mirror_buck1_ov_error,
			i_faults.mirror_buck1_pg_error, i_faults.mirror_power_good_error};
		detail_raw[1] = {5'h00, i_faults.aux_buck_ov_error, i_faults.aux_buck_pg_error, i_faults.ldo2_ov_error};
		detail_raw[2] = {4'h0, i_faults.lamp_ctrl2_ov_error, i_faults.lamp_ctrl2_pg_error,
			i_faults.lamp_ctrl1_ov_error, i_faults.lamp_ctrl1_pg_error};
		detail_raw[3] = {7'h00, mirror_rail_error};
	end

	// sticky summary flags, clear on read, set wins
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
			flags_r <= 8'h00;
		else if (rd && addr == `ADDR_FLAGS)
			flags_r <= flag_set;
		else
			flags_r <= flags_r | flag_set;
	end

	// sticky detail registers
	genvar gi;
	generate
		for (gi = 0; gi < N_DETAIL; gi++)
		begin : g_detail
			always_ff @(posedge i_clk_sys or negedge i_resetn)
			begin
				if (!i_resetn)
					detail_r[gi] <= 8'h00;
				else if (rd && addr == 7'(`ADDR_DETAIL_FIRST + gi))
					detail_r[gi] <= detail_raw[gi];
				else
					detail_r[gi] <= detail_r[gi] | detail_raw[gi];
			end
		end
	endgenerate

	// interrupt output
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
			int_n_r <= 1'b1;
		else
			int_n_r <= ~|(flags_r & ~masks_r);
	end

	// enable register
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
			enable_r <= `RST_ENABLE;
		else
		begin
			if (wr && addr == `ADDR_ENABLE && user_wr_ok(addr, nvm_ctrl_r[`BIT_GUARD]))
				enable_r <= i_acc.wdata;
			if (any_fault)
				enable_r[`BIT_RAILS_EN] <= 1'b0;
		end
	end

	// mask register
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
			masks_r <= `RST_MASKS;
		else if (wr && addr == `ADDR_MASKS && user_wr_ok(addr, nvm_ctrl_r[`BIT_GUARD]))
			masks_r <= i_acc.wdata;
	end

	// nonvolatile control: guard and commit
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
			nvm_ctrl_r <= `RST_NVM_CTRL;
		else if (wr && addr == `ADDR_NVM_CTRL)
			nvm_ctrl_r <= i_acc.wdata;
	end

	// unlock sequence
	always_comb
	begin
		key_nxt = key_r;
		case (key_r)
			KEY_LOCKED:
				if (wr && addr == `ADDR_KEY && i_acc.wdata == `KEY_FIRST)
					key_nxt = KEY_HALF;
			KEY_HALF:
				if (wr && addr == `ADDR_KEY && i_acc.wdata == `KEY_SECOND)
					key_nxt = KEY_OPEN;
				else if (wr && addr == `ADDR_KEY && i_acc.wdata == `KEY_FIRST)
					key_nxt = KEY_HALF;
				else if (i_acc.valid)
					key_nxt = KEY_LOCKED;
			KEY_OPEN:
				if (wr && addr == `ADDR_KEY && i_acc.wdata != `KEY_FIRST && i_acc.wdata != `KEY_SECOND)
					key_nxt = KEY_LOCKED;
			default:
				key_nxt = KEY_LOCKED;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
			key_r <= KEY_LOCKED;
		else
			key_r <= key_nxt;
	end

	// customer bytes
	generate
		for (gi = 0; gi < N_CUST; gi++)
		begin : g_cust
			always_ff @(posedge i_clk_sys or negedge i_resetn)
			begin
				if (!i_resetn)
					cust_r[gi] <= 8'h00;
				else if (wr && unlocked && addr == 7'(`ADDR_CUST_FIRST + gi))
					cust_r[gi] <= i_acc.wdata;
			end
		end
	endgenerate

	// read mux
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (addr == `ADDR_ENABLE)
			rdata_nxt = enable_r;
		else if (addr == `ADDR_FLAGS)
			rdata_nxt = flags_r;
		else if (addr == `ADDR_MASKS)
			rdata_nxt = masks_r;
		else if (in_range(addr, `ADDR_DETAIL_FIRST, `ADDR_DETAIL_LAST))
			rdata_nxt = detail_r[2'(addr - `ADDR_DETAIL_FIRST)];
		else if (addr == `ADDR_KEY)
			rdata_nxt = unlocked ? `KEY_READ_UNLOCKED : `KEY_READ_LOCKED;
		else if (addr == `ADDR_NVM_CTRL)
			rdata_nxt = nvm_ctrl_r;
		else if (in_range(addr, `ADDR_CUST_FIRST, `ADDR_CUST_LAST))
			rdata_nxt = cust_r[3'(addr - `ADDR_CUST_FIRST)];
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rvalid_r <= rd;
			if (rd)
				rdata_r <= rdata_nxt;
		end
	end

	// shutdown paths
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			fast_sd_r <= 1'b0;
			normal_sd_r <= 1'b0;
		end
		else
		begin
			fast_sd_r <= enable_r[`BIT_FAST_SD_EN] && fast_qualify;
			normal_sd_r <= !i_projector_power_pin;
		end
	end

	assign o_rdata = rdata_r;
	assign o_rvalid = rvalid_r;
	assign o_int_n = int_n_r;
	assign o_fast_shutdown = fast_sd_r;
	assign o_normal_shutdown = normal_sd_r;
	assign o_mirror_rails_enable = enable_r[`BIT_RAILS_EN];
	assign o_nvm_commit = nvm_ctrl_r[`BIT_COMMIT];

	// checks
	chk_flag_sets: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_faults.thermal_cutoff |=> flags_r[`BIT_FLG_TS_CUT])
		else $error("thermal cutoff flag not set");
	chk_int_low: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(|(flags_r & ~masks_r)) |=> !o_int_n)
		else $error("interrupt not driven low");
	chk_int_masked: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		masks_r[`BIT_FLG_THERMAL_CAUTION_FLAG] && (flags_r == 8'(1 << `BIT_FLG_THERMAL_CAUTION_FLAG)) |=> o_int_n)
		else $error("masked flag reached interrupt");
	chk_int_release: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!(|(flags_r & ~masks_r)) |=> o_int_n)
		else $error("interrupt not released");
	chk_rail_or: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_faults.aux_buck_ov_error |=> flags_r[`BIT_FLG_RAIL] && detail_r[1][2])
		else $error("aux overvoltage not in rail summary");
	chk_fast_start: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		enable_r[`BIT_FAST_SD_EN] && i_faults.lamp_ctrl2_ov_error |=> o_fast_shutdown)
		else $error("fast shutdown not started");
	chk_fast_only: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!fast_qualify |=> !o_fast_shutdown)
		else $error("fast shutdown on non qualifying fault");
	chk_protect_wr: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		wr && addr == `ADDR_MASKS && nvm_ctrl_r[`BIT_GUARD] |=> $stable(masks_r))
		else $error("protected register written");
	chk_key_gap: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		key_r == KEY_HALF && i_acc.valid && addr != `ADDR_KEY |=> key_r == KEY_LOCKED)
		else $error("unlock survived foreign access");
	chk_key_read: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		rd && addr == `ADDR_KEY |=> o_rvalid
		&& (o_rdata == ($past(unlocked) ? `KEY_READ_UNLOCKED : `KEY_READ_LOCKED)))
		else $error("key readback wrong");
	chk_cust_locked: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		wr && !unlocked && addr == `ADDR_CUST_FIRST |=> $stable(cust_r[0]))
		else $error("customer byte written while locked");
	chk_rails_off: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		any_fault |=> !o_mirror_rails_enable)
		else $error("rails enable not cleared on fault");
	cov_unlock: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
		key_r == KEY_HALF ##1 key_r == KEY_OPEN);
	cov_fast_sd: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) $rose(o_fast_shutdown));
	cov_int: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) $fell(o_int_n));
	cov_commit: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) $rose(o_nvm_commit));
endmodule

// *** test/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model
	import fault_irq_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid,
	output reg_acc_s o_acc
);
	initial o_acc = '0;
	// one access per call, held for exactly one taking edge
	task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge i_clk_sys);
		#1;
		o_acc = {1'b1, wr, a, d};
		@(posedge i_clk_sys);
		#1;
		q = i_rvalid ? i_rdata : 8'hXX;
		// released bus shows inverted leftovers, never the old request
		o_acc = {1'b0, ~o_acc.cmd, ~o_acc.wdata};
	endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
	import fault_irq_pkg::*;
;
	logic clk, rstn, pin, rvalid, int_n, fast, norm, rails, commit, half, open;
	logic [7:0] rdata, q;
	logic [19:0] f;
	logic [7:0] regs [0:127];
	reg_acc_s acc;
	int bad_count = 0;
	int n_checks = 0;
	int seed = 32'hdfc8;

	fault_irq_protect dut_u (.i_clk_sys(clk), .i_resetn(rstn), .i_projector_power_pin(pin), .i_faults(f),
		.i_acc(acc), .o_rdata(rdata), .o_rvalid(rvalid), .o_int_n(int_n), .o_fast_shutdown(fast),
		.o_normal_shutdown(norm), .o_mirror_rails_enable(rails), .o_nvm_commit(commit));
	spi_host_model host_u (.i_clk_sys(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_acc(acc));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#200000;
		bad_count++;
		complete_run();
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// model: live value of flag and detail registers from fault levels
	function automatic logic [7:0] cur(input logic [6:0] a);
		logic m;
		m = |f[14:6];
		case (a)
			7'h0C: return {m | f[5] | f[4], |f[3:0], f[19], f[18], f[17], f[16], f[15], 1'b0};
			7'h27: return {f[7], f[8], f[9], f[10], f[11], f[12], f[13], f[14]};
			7'h28: return {5'h00, f[4], f[5], f[6]};
			7'h29: return {4'h0, f[0], f[1], f[2], f[3]};
			7'h2A: return {7'h00, m};
			default: return 8'h00;
		endcase
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic setf(input logic [19:0] v);
		tick(1);
		f = v;
		regs[12] |= cur(7'h0C);
		for (int a = 39; a < 43; a++)
			regs[a] |= cur(7'(a));
		if (|f[18:16] & (f[18] | f[16]) | (|f[14:0]) & (|f[14:6] | |f[5:0]))
			regs[1][0] = 1'b0;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		if (a == 7'h2E)
		begin
			if (open && (d == 8'hBA || d == 8'hBE))
				open = 1'b1;
			else
				open = half && d == 8'hBE;
			half = !open && d == 8'hBA;
		end
		else
			half = 1'b0;
		if (((a == 7'h01 || a == 7'h0D) && !regs[47][0]) || a == 7'h2F || (a >= 7'h30 && a <= 7'h35 && open))
			regs[a] = d;
		host_u.access(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [6:0] a);
		half = 1'b0;
		host_u.access(1'b0, a, 8'h00, q);
		chk("rdata", (a == 7'h2E) ? {7'h00, open} : regs[a], q);
		if (a == 7'h0C || (a >= 7'h27 && a <= 7'h2A))
			regs[a] = cur(a);
	endtask

	task automatic do_reset();
		rstn = 1'b0;
		regs = '{default: 8'h00};
		regs[1] = 8'h82;
		half = 1'b0;
		open = 1'b0;
		tick(6);
		rstn = 1'b1;
		chk("int_n", 8'h01, {7'h00, int_n});
		chk("rails", 8'h00, {7'h00, rails});
	endtask

	task automatic clear_flags();
		setf(20'h0);
		rd(7'h0C);
		for (int a = 39; a < 43; a++)
			rd(7'(a));
		rd(7'h0C);
	endtask

	initial
	begin
		pin = 1'b1;
		f = 20'h0;
		do_reset();
		rd(7'h01);
		rd(7'h2E);
		for (int k = 0; k < 28; k++)
		begin
			wr(7'h01, 8'h83);
			setf((k < 20) ? (20'h1 << k) : 20'($random(seed)));
			tick(3);
			chk("int_n", {7'h00, ~|(regs[12] & ~regs[13])}, {7'h00, int_n});
			chk("fast", {7'h00, f[18] | f[16] | (|f[14:6]) | f[2] | f[0]}, {7'h00, fast});
			chk("rails", {7'h00, regs[1][0]}, {7'h00, rails});
			rd(7'h0C);
			clear_flags();
			tick(3);
			chk("int_n", 8'h01, {7'h00, int_n});
		end
		wr(7'h0D, 8'h02);
		setf(20'h08000);
		tick(3);
		chk("int_n", 8'h01, {7'h00, int_n});
		rd(7'h0C);
		wr(7'h0D, 8'h00);
		tick(2);
		chk("int_n", 8'h00, {7'h00, int_n});
		clear_flags();
		wr(7'h01, 8'h01);
		setf(20'h40000);
		tick(3);
		chk("fast", 8'h00, {7'h00, fast});
		clear_flags();
		pin = 1'b0;
		tick(3);
		chk("normal", 8'h01, {7'h00, norm});
		pin = 1'b1;
		tick(3);
		chk("normal", 8'h00, {7'h00, norm});
		wr(7'h0D, 8'h5A);
		rd(7'h0D);
		wr(7'h0C, 8'hFF);
		rd(7'h0C);
		wr(7'h50, 8'h77);
		rd(7'h50);
		wr(7'h2F, 8'h01);
		wr(7'h0D, 8'hA5);
		rd(7'h0D);
		wr(7'h01, 8'h80);
		rd(7'h01);
		wr(7'h2F, 8'h00);
		wr(7'h0D, 8'h00);
		rd(7'h0D);
		wr(7'h30, 8'h11);
		rd(7'h30);
		wr(7'h2E, 8'hBA);
		wr(7'h2E, 8'hBE);
		rd(7'h2E);
		for (int i = 0; i < 6; i++)
			wr(7'(48 + i), 8'($random(seed)));
		for (int i = 0; i < 6; i++)
			rd(7'(48 + i));
		wr(7'h2E, 8'hBA);
		rd(7'h2E);
		wr(7'h2E, 8'h00);
		rd(7'h2E);
		wr(7'h31, 8'h3C);
		rd(7'h31);
		wr(7'h2E, 8'hBA);
		rd(7'h0D);
		wr(7'h2E, 8'hBE);
		rd(7'h2E);
		wr(7'h2F, 8'h02);
		tick(2);
		chk("commit", 8'h01, {7'h00, commit});
		tick(20);
		wr(7'h2F, 8'h00);
		tick(2);
		chk("commit", 8'h00, {7'h00, commit});
		wr(7'h2E, 8'hBA);
		wr(7'h2E, 8'hBE);
		do_reset();
		rd(7'h2E);
		rd(7'h01);
		complete_run();
	end
endmodule
